// ### cbt_bus_model.sv
// Model of the other nodes sharing the bus: it answers each attempt as commanded.
`timescale 1ns/1ns
module cbt_bus_model (
  input wire logic sys_clk,
  input wire logic tx_start,
  input wire logic [1:0] mode,
  output logic bus_idle = 1'b1,
  output logic tx_error = 1'b0,
  output logic arb_lost = 1'b0,
  output logic tx_done = 1'b0
);
  logic [2:0] step = 3'h0;
  // The bus stays busy through an attempt and frees two cycles after its outcome.
  always @(posedge sys_clk) begin
    tx_error <= (step == 3'h4) && (mode == 2'h1);
    arb_lost <= (step == 3'h4) && (mode == 2'h2);
    tx_done <= (step == 3'h4) && (mode == 2'h0);
    if (tx_start) begin
      step <= 3'h1;
      bus_idle <= 1'b0;
    end else if (step != 3'h0) begin
      step <= (step == 3'h6) ? 3'h0 : step + 3'h1;
      bus_idle <= (step == 3'h6);
    end
  end
endmodule

// ### cbt_checker_assertions.sv
// Checker of bus handshake, bit pulse and retry relations at the block ports.
`timescale 1ns/1ns
module cbt_checker #(
  parameter int SYNC_DELAY = 3
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic bus_idle,
  input wire logic tx_request,
  input wire logic arb_lost,
  input wire logic sample_point,
  input wire logic bit_start,
  input wire logic tx_start,
  input wire logic tx_abort,
  input wire logic tx_give_up,
  input wire logic limit_sync_busy
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  logic [4:0] busy_run;
  always_ff @(posedge sys_clk) begin
    busy_run <= (nrst && limit_sync_busy) ? busy_run + 5'h01 : 5'h00;
  end
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  a_sample_gap: assert property (sample_point |=> !sample_point [*2])
    else $error("sample pulses too close");
  a_bit_gap: assert property (bit_start |=> !bit_start [*2])
    else $error("bit starts too close");
  a_abort_prompt: assert property (arb_lost |-> ##[0:3] (tx_abort || tx_give_up))
    else $error("no reaction to lost arbitration");
  a_start_cause: assert property (
    tx_start |-> $past(bus_idle) && $past(tx_request))
    else $error("attempt on busy bus");
  a_sync_bound: assert property (busy_run <= SYNC_DELAY + 1)
    else $error("limit transfer too long");
  a_giveup_alone: assert property (tx_give_up |-> !tx_start)
    else $error("attempt while giving up");
endmodule
bind cbt_top cbt_checker #(.SYNC_DELAY(SYNC_DELAY)) cbt_checker_inst (.sys_clk(sys_clk),
  .nrst(nrst), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .bus_idle(bus_idle),
  .tx_request(tx_request), .arb_lost(arb_lost), .sample_point(sample_point),
  .bit_start(bit_start), .tx_start(tx_start), .tx_abort(tx_abort), .tx_give_up(tx_give_up),
  .limit_sync_busy(limit_sync_busy));

// ### cbt_pkg.sv
// Package with register map, field layout and timing constants of the bit timing block.
package cbt_pkg;
  localparam logic [4:0] ADDR_BIT_TIMING = 5'h04;
  localparam logic [4:0] ADDR_RETRY_PRESCALE = 5'h10;
  localparam logic [31:0] RESET_BIT_TIMING = 32'h05050008;
  localparam logic [31:0] RESET_RETRY_PRESCALE = 32'h77000000;
  localparam logic [31:0] MASK_BIT_TIMING = 32'h7F7F01FF;
  localparam logic [31:0] MASK_RETRY_PRESCALE = 32'h7700001F;
  localparam int SJW_LSB = 24;
  localparam int SEG2_LSB = 16;
  localparam int SEG1_LSB = 0;
  localparam int RETRANSMIT_LIMIT_LSB = 28;
  localparam int REARBITRATION_LIMIT_LSB = 24;
  localparam int DIV_LSB = 0;
  localparam logic [2:0] LIMIT_UNLIMITED = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] TEC_BUS_OFF = 8'hFF;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [1:0] {CBT_IDLE, CBT_ARB, CBT_SEND} cbt_tx_e;
endpackage

// ### cbt_top.sv
// CAN bit timing generator, retry limits and AXI4-Lite register slave.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Overview of operation
// - Time quantum is the module clock divided by divider field plus one.
// - Each resynchronisation step is limited to jump width plus one quanta.
// - Sample point to bit end lasts after-sample field plus one quanta.
// - Sample point falls before-sample field plus two quanta after bit start.
// - Retransmit limit: 7 limited only by error count, 6 seven tries, 0 one.
// - After a transmit error retry on idle bus until the limit is reached.
// - Re-arbitration limit: 7 unlimited, 6 seven tries, 0 single attempt.
// - On lost arbitration stop sending, retry on idle bus within limit.
// - Retransmit limit update accepted anytime, passed to engine over several clocks.
// - Re-arbitration limit update accepted anytime, passed over several clocks.
module cbt_top #(
  parameter int SYNC_DELAY = cbt_pkg::SYNC_STAGES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_edge,
  input wire logic bus_idle,
  input wire logic tx_request,
  input wire logic tx_error,
  input wire logic arb_lost,
  input wire logic tx_done,
  input wire logic [7:0] transmit_error_count,
  output logic tq_tick,
  output logic sample_point,
  output logic bit_start,
  output logic tx_start,
  output logic tx_abort,
  output logic tx_give_up,
  output logic limit_sync_busy
);
  // The transfer countdown is four bits wide, so the delay must fit in it and be nonzero.
  if (SYNC_DELAY < 1 || SYNC_DELAY > 15) begin : gen_bad_sync_delay
    $error("SYNC_DELAY out of range");
  end

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [4:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic [31:0] bit_timing;
    logic [31:0] retry_prescale;
    logic [3:0] sync_cnt;
    logic [2:0] eng_retransmit_limit;
    logic [2:0] eng_rearbitration_limit;
    logic [4:0] div_cnt;
    logic [9:0] tq_cnt;
    logic [10:0] bit_len;
    logic tq_tick;
    logic sample_point;
    logic bit_start;
    cbt_pkg::cbt_tx_e tx_state;
    logic [2:0] tx_tries;
    logic [2:0] arb_tries;
    logic tx_start;
    logic tx_abort;
    logic tx_give_up;
    logic busy;
  } cbt_state_s;

  cbt_state_s st;
  cbt_state_s next_st;

  function automatic logic [31:0] cbt_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // A limit code of seven is unlimited; otherwise code n allows n plus one tries.
  function automatic logic cbt_limit_hit(input logic [2:0] limit, input logic [2:0] tries);
    return (limit != cbt_pkg::LIMIT_UNLIMITED) && (tries >= limit);
  endfunction

  logic [4:0] tq_div;
  logic [6:0] sjw;
  logic [6:0] seg2;
  logic [8:0] seg1;
  logic [9:0] sample_at;
  logic [10:0] nominal_len;
  logic [10:0] min_len;
  logic wr_go;

  always_comb begin
    tq_div = st.retry_prescale[cbt_pkg::DIV_LSB +: 5];
    sjw = st.bit_timing[cbt_pkg::SJW_LSB +: 7];
    seg2 = st.bit_timing[cbt_pkg::SEG2_LSB +: 7];
    seg1 = st.bit_timing[cbt_pkg::SEG1_LSB +: 9];
    sample_at = 10'(seg1) + 10'h002;
    nominal_len = 11'(sample_at) + 11'(seg2) + 11'h001;
    min_len = 11'(sample_at) + 11'h001;
    wr_go = (st.aw_held || s_axi_awvalid) && (st.w_held || s_axi_wvalid) && !st.bvalid;
  end

  always_comb begin
    logic [4:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic [10:0] adj;
    logic [10:0] shortened;
    waddr = 5'h00;
    wdat = 32'h00000000;
    wstb = 4'h0;
    adj = 11'h000;
    shortened = 11'h000;
    next_st = st;
    next_st.tq_tick = 1'b0;
    next_st.sample_point = 1'b0;
    next_st.bit_start = 1'b0;
    next_st.tx_start = 1'b0;
    next_st.tx_abort = 1'b0;
    next_st.tx_give_up = 1'b0;

    // Limits reach the engine copy only after the synchronisation delay.
    // The countdown comes first so that a write in its last cycle still restarts it.
    if (st.sync_cnt != 4'h0) begin
      next_st.sync_cnt = st.sync_cnt - 4'h1;
      if (st.sync_cnt == 4'h1) begin
        next_st.eng_retransmit_limit = st.retry_prescale[cbt_pkg::RETRANSMIT_LIMIT_LSB +: 3];
        next_st.eng_rearbitration_limit = st.retry_prescale[cbt_pkg::REARBITRATION_LIMIT_LSB +: 3];
        next_st.busy = 1'b0;
      end
    end

    // Write channel: address and data may arrive in either order.
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    if (wr_go) begin
      waddr = st.aw_held ? st.awaddr : s_axi_awaddr;
      wdat = st.w_held ? st.wdata : s_axi_wdata;
      wstb = st.w_held ? st.wstrb : s_axi_wstrb;
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.awready = 1'b0;
      next_st.wready = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = cbt_pkg::RESP_OKAY;
      if (waddr == cbt_pkg::ADDR_BIT_TIMING) begin
        next_st.bit_timing = cbt_merge(st.bit_timing, wdat, wstb, cbt_pkg::MASK_BIT_TIMING);
      end else if (waddr == cbt_pkg::ADDR_RETRY_PRESCALE) begin
        next_st.retry_prescale = cbt_merge(st.retry_prescale, wdat, wstb,
                                           cbt_pkg::MASK_RETRY_PRESCALE);
        if (wstb[3]) begin
          next_st.sync_cnt = 4'(SYNC_DELAY);
          next_st.busy = 1'b1;
        end
      end else begin
        next_st.bresp = cbt_pkg::RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // Read channel.
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = cbt_pkg::RESP_OKAY;
      if (s_axi_araddr == cbt_pkg::ADDR_BIT_TIMING) begin
        next_st.rdata = st.bit_timing;
      end else if (s_axi_araddr == cbt_pkg::ADDR_RETRY_PRESCALE) begin
        next_st.rdata = st.retry_prescale;
      end else begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = cbt_pkg::RESP_SLVERR;
      end
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // Time quantum prescaler.
    if (st.div_cnt >= tq_div) begin
      next_st.div_cnt = 5'h00;
      next_st.tq_tick = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 5'h01;
    end

    // Bit timing in quanta; a bus edge resynchronises within the jump width plus one quanta.
    if (st.tq_tick) begin
      if (st.tq_cnt == 10'h000) begin
        next_st.bit_start = 1'b1;
      end
      if (rx_edge && st.tq_cnt != 10'h000) begin
        if (11'(st.tq_cnt) < 11'(sample_at)) begin
          adj = (11'(st.tq_cnt) > 11'(sjw) + 11'h001) ? 11'(sjw) + 11'h001 : 11'(st.tq_cnt);
          next_st.bit_len = st.bit_len + adj;
        end else begin
          adj = st.bit_len - 11'(st.tq_cnt);
          adj = (adj > 11'(sjw) + 11'h001) ? 11'(sjw) + 11'h001 : adj;
          shortened = st.bit_len - adj;
          next_st.bit_len = (shortened < min_len) ? min_len : shortened;
        end
      end
      if (st.tq_cnt == sample_at - 10'h001) begin
        next_st.sample_point = 1'b1;
      end
      // The end test uses the adjusted length so that a shortening takes effect at once.
      if (11'(st.tq_cnt) + 11'h001 >= next_st.bit_len) begin
        next_st.tq_cnt = 10'h000;
        next_st.bit_len = nominal_len;
      end else begin
        next_st.tq_cnt = st.tq_cnt + 10'h001;
      end
    end

    // Transmit attempt sequencing with retry and re-arbitration limits.
    case (st.tx_state)
      cbt_pkg::CBT_IDLE: begin
        if (tx_request && bus_idle) begin
          next_st.tx_state = cbt_pkg::CBT_ARB;
          next_st.tx_start = 1'b1;
        end
      end
      cbt_pkg::CBT_ARB, cbt_pkg::CBT_SEND: begin
        if (tx_done) begin
          next_st.tx_state = cbt_pkg::CBT_IDLE;
          next_st.tx_tries = 3'h0;
          next_st.arb_tries = 3'h0;
        end else if (arb_lost) begin
          next_st.tx_abort = 1'b1;
          if (cbt_limit_hit(st.eng_rearbitration_limit, st.arb_tries)) begin
            next_st.tx_give_up = 1'b1;
            next_st.tx_state = cbt_pkg::CBT_IDLE;
            next_st.arb_tries = 3'h0;
            next_st.tx_tries = 3'h0;
          end else begin
            next_st.arb_tries = st.arb_tries + 3'h1;
            next_st.tx_state = cbt_pkg::CBT_SEND;
          end
        end else if (tx_error) begin
          if (cbt_limit_hit(st.eng_retransmit_limit, st.tx_tries) ||
              transmit_error_count == cbt_pkg::TEC_BUS_OFF) begin
            next_st.tx_give_up = 1'b1;
            next_st.tx_state = cbt_pkg::CBT_IDLE;
            next_st.tx_tries = 3'h0;
            next_st.arb_tries = 3'h0;
          end else begin
            next_st.tx_tries = (st.tx_tries == cbt_pkg::LIMIT_UNLIMITED) ? st.tx_tries
                                                                        : st.tx_tries + 3'h1;
            next_st.tx_state = cbt_pkg::CBT_SEND;
          end
        end else if (st.tx_state == cbt_pkg::CBT_SEND && bus_idle && !st.tx_abort) begin
          next_st.tx_start = 1'b1;
          next_st.tx_state = cbt_pkg::CBT_ARB;
        end
      end
      default: begin
        next_st.tx_state = cbt_pkg::CBT_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.bit_timing <= cbt_pkg::RESET_BIT_TIMING;
      st.retry_prescale <= cbt_pkg::RESET_RETRY_PRESCALE;
      st.eng_retransmit_limit <= cbt_pkg::LIMIT_UNLIMITED;
      st.eng_rearbitration_limit <= cbt_pkg::LIMIT_UNLIMITED;
      // The first bit after reset already has the nominal length of the reset fields.
      st.bit_len <= 11'(cbt_pkg::RESET_BIT_TIMING[cbt_pkg::SEG1_LSB +: 9])
                    + 11'(cbt_pkg::RESET_BIT_TIMING[cbt_pkg::SEG2_LSB +: 7])
                    + 11'h003;
      st.tx_state <= cbt_pkg::CBT_IDLE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;
  assign tq_tick = st.tq_tick;
  assign sample_point = st.sample_point;
  assign bit_start = st.bit_start;
  assign tx_start = st.tx_start;
  assign tx_abort = st.tx_abort;
  assign tx_give_up = st.tx_give_up;
  assign limit_sync_busy = st.busy;
endmodule

// ### test_can_bit_timing_retry_limits.sv
// Bench for the bit timing and retry limit block with a bus node model.
`timescale 1ns/1ns
module test_can_bit_timing_retry_limits;
  logic sys_clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
  logic rry = 1'b0, treq = 1'b0, rx_edge = 1'b0;
  logic [4:0] aw = 5'h00, ar = 5'h00;
  logic [31:0] wd = 32'h00000000, rd;
  logic [7:0] tec = 8'h00;
  logic [1:0] mode = 2'h0, br, rr;
  logic awr, wrdy, bv, arr, rv, idle, terr, alost, tdone, tick, samp, bst, tst, abort, gup, busy;
  int fails = 0;
  int n_tests = 0;
  always #4 sys_clk = ~sys_clk;
  cbt_top cbt_top_inst (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .rx_edge(rx_edge), .bus_idle(idle), .tx_request(treq), .tx_error(terr), .arb_lost(alost),
    .tx_done(tdone), .transmit_error_count(tec), .tq_tick(tick), .sample_point(samp),
    .bit_start(bst), .tx_start(tst), .tx_abort(abort), .tx_give_up(gup), .limit_sync_busy(busy));
  cbt_bus_model cbt_bus_model_inst (.sys_clk(sys_clk), .tx_start(tst), .mode(mode),
    .bus_idle(idle), .tx_error(terr), .arb_lost(alost), .tx_done(tdone));
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic stuck();
    fails++;
    give_verdict();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One register access; a read compares its data with d.
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int i;
    logic ta, tw, td;
    logic [1:0] rsp;
    logic [31:0] dat;
    @(posedge sys_clk);
    aw <= a;
    ar <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    bry <= w;
    arv <= !w;
    rry <= !w;
    for (i = 0; i < 50; i++) begin
      @(negedge sys_clk);
      ta = (awv && awr) || (arv && arr);
      tw = wv && wrdy;
      td = (bv && bry) || (rv && rry);
      rsp = w ? br : rr;
      dat = rd;
      @(posedge sys_clk);
      if (ta) begin
        awv <= 1'b0;
        arv <= 1'b0;
      end
      if (tw) wv <= 1'b0;
      if (td) begin
        bry <= 1'b0;
        rry <= 1'b0;
        break;
      end
    end
    if (i == 50) stuck();
    check(rsp, er);
    if (!w) check(dat, d);
  endtask
  task automatic set_lim(input logic [2:0] rt, input logic [2:0] ra, input logic [4:0] dv);
    int i;
    logic s = 1'b0;
    acc(1'b1, 5'h10, {1'b0, rt, 1'b0, ra, 19'h0, dv}, 2'h0);
    for (i = 0; i < 40 && !(s && !busy); i++) begin
      @(negedge sys_clk);
      s |= busy;
    end
    check(s, 1'b1);
    check(busy, 1'b0);
  endtask
  // The longest bit left by the register test spans well over a thousand clocks.
  task automatic wait_bit();
    int i;
    for (i = 0; i < 4000; i++) begin
      @(negedge sys_clk);
      if (bst) break;
    end
    if (i == 4000) stuck();
  endtask
  // Holds a bus edge for one quantum from at clocks after a bit start and times that bit.
  task automatic resync(input int at, input int exp);
    int n;
    wait_bit();
    repeat (at) @(posedge sys_clk);
    rx_edge <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rx_edge <= 1'b0;
    n = at + 1;
    do begin
      @(negedge sys_clk);
      n++;
    end while (!bst && n < 100);
    check(n, exp);
  endtask
  task automatic run(input logic [1:0] m, input int ns, input logic eg);
    int i, n = 0, na = 0;
    logic g = 1'b0;
    @(posedge sys_clk);
    mode <= m;
    treq <= 1'b1;
    for (i = 0; i < 3000 && !(g || tdone); i++) begin
      @(negedge sys_clk);
      n += tst;
      na += abort;
      g |= gup;
    end
    @(posedge sys_clk);
    treq <= 1'b0;
    if (i == 3000) stuck();
    check(n, ns);
    check(g, eg);
    check(na, (m == 2'h2) ? ns : 0);
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic t_regs();
    acc(1'b0, 5'h04, 32'h05050008, 2'h0);
    acc(1'b0, 5'h10, 32'h77000000, 2'h0);
    acc(1'b0, 5'h08, 32'h00000000, 2'h2);
    acc(1'b1, 5'h0C, 32'hFFFFFFFF, 2'h2);
    acc(1'b1, 5'h04, 32'hFFFFFFFF, 2'h0);
    acc(1'b0, 5'h04, 32'h7F7F01FF, 2'h0);
    set_lim(3'h7, 3'h7, 5'h1F);
    acc(1'b0, 5'h10, 32'h7700001F, 2'h0);
    $display("register test done");
  endtask
  task automatic t_timing();
    int n = 0, tq = 0, sp = 0;
    acc(1'b1, 5'h04, 32'h00010002, 2'h0);
    set_lim(3'h7, 3'h7, 5'h01);
    wait_bit();
    wait_bit();
    do begin
      @(negedge sys_clk);
      n++;
      tq += tick;
      sp += samp;
    end while (!bst && n < 100);
    check(n, 12);
    check(tq, 6);
    check(sp, 1);
    // An edge before the sample point lengthens the bit by one quantum, one after shortens it.
    resync(1, 14);
    resync(7, 10);
    $display("timing test done");
  endtask
  task automatic t_retry();
    set_lim(3'h0, 3'h7, 5'h00);
    run(2'h1, 1, 1'b1);
    set_lim(3'h6, 3'h7, 5'h00);
    run(2'h1, 7, 1'b1);
    set_lim(3'h7, 3'h0, 5'h00);
    run(2'h2, 1, 1'b1);
    set_lim(3'h7, 3'h6, 5'h00);
    run(2'h2, 7, 1'b1);
    tec <= 8'hFF;
    run(2'h1, 1, 1'b1);
    tec <= 8'h00;
    run(2'h0, 1, 1'b0);
    $display("retry test done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_timing();
    t_retry();
    give_verdict();
  end
endmodule
